// file: flash_host_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// R1 - Timing limit flag marks a failed operation
// R2 - Programming 0 to 1 is masked silently
// R3 - After timing limit, send software reset
// R4 - Erase window flag 0 then 1 on expiry
// R5 - Window flag 1 means erase started
// R6 - Host confirms acceptance, checks window flag
// R7 - Buffer abort needs dedicated abort reset sequence
// R8 - Program status bits pattern while busy
// R9 - Status reads use a valid address
// R10 - Poll last loaded buffer address
// R11 - Address on falling, data on rising strobe
// R12 - Array uses uniform 64KW/128KB sectors
// R13 - Ready/busy open drain, low while busy
// R14 - Reset pin low aborts and clears device
// R15 - Host restarts operations cut by reset; the controller leaves this to the caller
// R16 - Single 00F0h write is software reset
// R17 - Host uses software reset for exits
// R18 - Software reset ignored while operation runs
// R19 - Reset before third cycle abandons program
// R20 - Reset from suspend returns suspend-read
// R21 - Unlock bypass needs two-cycle exit
// R22 - Bypass exit writes 0090h then 0000h
// R23 - Toggle bit one inverts while busy
// R24 - Idle reads return array contents
module flash_host_ctrl (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// User request
	input wire logic req_valid_in,
	input wire flash_host_pkg::req_s req_in,
	output logic req_ready_out,
	// User answer
	output logic done_out,
	output logic [flash_host_pkg::DATA_W-1:0] rd_data_out,
	output flash_host_pkg::result_s result_out,
	output logic ready_out,
	// Flash pins
	output flash_host_pkg::pins_s pins_out,
	input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
	input wire logic ready_busy_n_in
);
	import flash_host_pkg::*;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_SETUP = 9'h002,
		ST_WLOW = 9'h004,
		ST_WHOLD = 9'h008,
		ST_RLOW = 9'h010,
		ST_RSAMP = 9'h020,
		ST_EVAL = 9'h040,
		ST_RSTLOW = 9'h080,
		ST_RSTREC = 9'h100
	} state_e;

	// Word and address of step n of a write sequence
	function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input op_e op, input logic [1:0] step,
		input logic [ADDR_W-1:0] base, input logic [DATA_W-1:0] data);
		logic [ADDR_W+DATA_W-1:0] w;
		w = {base, data};
		unique case (op)
			OP_SW_RESET: w = {base, CMD_SW_RESET}; // [R16]
			OP_BYPASS_EXIT: w = (step == 2'h0) ? {base, CMD_BYPASS_EXIT_1} : {base, CMD_BYPASS_EXIT_2}; // [R21] [R22]
			OP_ABORT_RESET: begin // [R7]
				unique case (step)
					2'h0: w = {base + UNLOCK_OFS_1, CMD_UNLOCK_1};
					2'h1: w = {base + UNLOCK_OFS_2, CMD_UNLOCK_2};
					default: w = {base + UNLOCK_OFS_1, CMD_SW_RESET};
				endcase
			end
			default: w = {base, data};
		endcase
		return w;
	endfunction

	function automatic logic [1:0] seq_last(input op_e op);
		unique case (op)
			OP_BYPASS_EXIT: return 2'h1;
			OP_ABORT_RESET: return 2'h2;
			default: return 2'h0;
		endcase
	endfunction

	state_e state_ff, nxt_state;
	req_s req_ff, nxt_req;
	logic [1:0] step_ff, nxt_step;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic tog_ff, nxt_tog;
	logic recheck_ff, nxt_recheck;
	result_s res_ff, nxt_res;
	logic done_ff, nxt_done;
	logic [DATA_W-1:0] rd_ff, nxt_rd;
	pins_s pins_ff, nxt_pins;
	logic [DATA_W-1:0] dq_meta_ff, dq_sync_ff;
	logic rb_meta_ff, rb_sync_ff;

	wire is_read = (req_ff.op == OP_READ) || (req_ff.op == OP_POLL);
	wire cnt_zero = (cnt_ff == '0);
	wire step_is_last = (step_ff == seq_last(req_ff.op));
	wire toggled = dq_sync_ff[TOGGLE_BIT_ONE] != tog_ff; // [R23]
	wire hit_timing = dq_sync_ff[TIMING_LIMIT_BIT]; // [R1]
	wire hit_abort = dq_sync_ff[BUFFER_ABORT_BIT];

	assign req_ready_out = (state_ff == ST_IDLE);
	assign done_out = done_ff;
	assign rd_data_out = rd_ff;
	assign result_out = res_ff;
	// Device pulls low while busy; a pull-up outside gives the high
	assign ready_out = rb_sync_ff; // [R13]
	assign pins_out = pins_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_req = req_ff;
		nxt_step = step_ff;
		nxt_cnt = cnt_zero ? cnt_ff : cnt_ff - 1'b1;
		nxt_tog = tog_ff;
		nxt_recheck = recheck_ff;
		nxt_res = res_ff;
		nxt_done = 1'b0;
		nxt_rd = rd_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (req_valid_in) begin
					nxt_req = req_in;
					nxt_step = 2'h0;
					nxt_recheck = 1'b0;
					nxt_res = '0;
					if (req_in.op == OP_HW_RESET) begin
						nxt_state = ST_RSTLOW;
						nxt_cnt = CNT_W'(RESET_PULSE_CYC - 1); // [R14]
					end else begin
						nxt_state = ST_SETUP;
						nxt_cnt = CNT_W'(SETUP_CYC - 1);
					end
				end
			end
			ST_SETUP: if (cnt_zero) begin
				nxt_state = is_read ? ST_RLOW : ST_WLOW;
				nxt_cnt = is_read ? CNT_W'(ACCESS_CYC - 1) : CNT_W'(STROBE_CYC - 1);
			end
			ST_WLOW: if (cnt_zero) begin
				nxt_state = ST_WHOLD;
				nxt_cnt = CNT_W'(HOLD_CYC - 1);
			end
			ST_WHOLD: if (cnt_zero) begin
				if (step_is_last) begin
					nxt_state = ST_IDLE;
					nxt_done = 1'b1;
					nxt_res.op_ok = !res_ff.timing_fail && !res_ff.buffer_aborted;
				end else begin
					nxt_step = step_ff + 2'h1;
					nxt_state = ST_SETUP;
					nxt_cnt = CNT_W'(SETUP_CYC - 1);
				end
			end
			ST_RLOW: if (cnt_zero) nxt_state = ST_RSAMP;
			ST_RSAMP: begin
				nxt_rd = dq_sync_ff; // [R24]
				nxt_state = (req_ff.op == OP_POLL) ? ST_EVAL : ST_IDLE;
				nxt_done = (req_ff.op == OP_READ);
				nxt_res.op_ok = (req_ff.op == OP_READ);
			end
			ST_EVAL: begin
				nxt_res.erase_window = dq_sync_ff[ERASE_WINDOW_BIT]; // [R4] [R5] [R6]
				nxt_cnt = CNT_W'(SETUP_CYC - 1);
				if (step_ff == 2'h0) begin
					// First of a pair: remember the toggle bit, read again
					nxt_tog = dq_sync_ff[TOGGLE_BIT_ONE];
					nxt_step = 2'h1;
					nxt_state = ST_SETUP;
				end else if (!toggled) begin
					nxt_state = ST_IDLE;
					nxt_done = 1'b1;
					nxt_res.op_ok = 1'b1;
				end else if (hit_abort) begin
					nxt_res.buffer_aborted = 1'b1;
					nxt_req.op = OP_ABORT_RESET; // [R7]
					nxt_step = 2'h0;
					nxt_state = ST_SETUP;
				end else if (hit_timing && !recheck_ff) begin
					// Toggle may have stopped just as the flag rose
					nxt_recheck = 1'b1;
					nxt_step = 2'h0;
					nxt_state = ST_SETUP;
				end else if (hit_timing) begin
					nxt_res.timing_fail = 1'b1;
					nxt_req.op = OP_SW_RESET; // [R3] [R17]
					nxt_step = 2'h0;
					nxt_state = ST_SETUP;
				end else begin
					// Still running; a software reset now would be ignored
					nxt_state = ST_IDLE; // [R18]
					nxt_done = 1'b1;
					nxt_res.still_busy = 1'b1;
				end
			end
			ST_RSTLOW: if (cnt_zero) begin
				nxt_state = ST_RSTREC;
				nxt_cnt = CNT_W'(RESET_RECOVER_CYC - 1);
			end
			ST_RSTREC: if (cnt_zero) begin
				// Caller must restart any interrupted program or erase
				nxt_state = ST_IDLE; // [R15]
				nxt_done = 1'b1;
				nxt_res.op_ok = 1'b1;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// Pins follow the next state so they leave flip-flops glitch-free
	wire nxt_bus = (nxt_state == ST_SETUP) || (nxt_state == ST_WLOW) || (nxt_state == ST_WHOLD) ||
		(nxt_state == ST_RLOW);
	wire nxt_is_read = (nxt_req.op == OP_READ) || (nxt_req.op == OP_POLL);
	wire [ADDR_W+DATA_W-1:0] nxt_word = seq_word(nxt_req.op, nxt_step, nxt_req.addr, nxt_req.data);

	always_comb begin
		nxt_pins.chip_select_n = !((nxt_state == ST_SETUP) || (nxt_state == ST_WLOW) || (nxt_state == ST_RLOW)); // [R11]
		nxt_pins.write_strobe_n = !(nxt_state == ST_WLOW); // [R11]
		nxt_pins.output_strobe_n = !(nxt_state == ST_RLOW);
		nxt_pins.hw_reset_n = !(nxt_state == ST_RSTLOW); // [R14]
		nxt_pins.addr = nxt_bus ? nxt_word[ADDR_W+DATA_W-1:DATA_W] : pins_ff.addr; // [R9] [R10]
		nxt_pins.dq = nxt_word[DATA_W-1:0]; // [R2]
		nxt_pins.dq_oe = nxt_bus && !nxt_is_read; // [R11]
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			dq_meta_ff <= '0;
			dq_sync_ff <= '0;
			rb_meta_ff <= 1'b1;
			rb_sync_ff <= 1'b1;
		end else begin
			dq_meta_ff <= dq_in;
			dq_sync_ff <= dq_meta_ff;
			rb_meta_ff <= ready_busy_n_in;
			rb_sync_ff <= rb_meta_ff;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff <= ST_IDLE;
			req_ff <= '0;
			step_ff <= 2'h0;
			cnt_ff <= '0;
			tog_ff <= 1'b0;
			recheck_ff <= 1'b0;
			res_ff <= '0;
			done_ff <= 1'b0;
			rd_ff <= '0;
			pins_ff <= '{chip_select_n: 1'b1, write_strobe_n: 1'b1, output_strobe_n: 1'b1,
				hw_reset_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0};
		end else begin
			state_ff <= nxt_state;
			req_ff <= nxt_req;
			step_ff <= nxt_step;
			cnt_ff <= nxt_cnt;
			tog_ff <= nxt_tog;
			recheck_ff <= nxt_recheck;
			res_ff <= nxt_res;
			done_ff <= nxt_done;
			rd_ff <= nxt_rd;
			pins_ff <= nxt_pins;
		end
	end

endmodule // flash_host_ctrl

// file: flash_host_pkg.sv
package flash_host_pkg;

	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;
	localparam int CLK_NS = 40;

	// Strobe timing targets, in ns
	localparam int SETUP_NS = 40;
	localparam int STROBE_NS = 80;
	localparam int HOLD_NS = 40;
	localparam int ACCESS_NS = 120;
	localparam int RESET_PULSE_NS = 500;
	localparam int RESET_RECOVER_NS = 1000;

	// Least times round up, never below one cycle
	function automatic int min_cycles(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int SETUP_CYC = min_cycles(SETUP_NS);
	localparam int STROBE_CYC = min_cycles(STROBE_NS);
	localparam int HOLD_CYC = min_cycles(HOLD_NS);
	// Two extra cycles cover the input synchroniser
	localparam int ACCESS_CYC = min_cycles(ACCESS_NS) + 2;
	localparam int RESET_PULSE_CYC = min_cycles(RESET_PULSE_NS);
	localparam int RESET_RECOVER_CYC = min_cycles(RESET_RECOVER_NS);
	localparam int CNT_W = 8;

	// Command words
	localparam logic [DATA_W-1:0] CMD_SW_RESET = 16'h00F0;
	localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT_1 = 16'h0090;
	localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT_2 = 16'h0000;
	localparam logic [DATA_W-1:0] CMD_UNLOCK_1 = 16'h00AA;
	localparam logic [DATA_W-1:0] CMD_UNLOCK_2 = 16'h0055;
	localparam logic [ADDR_W-1:0] UNLOCK_OFS_1 = 26'h0000555;
	localparam logic [ADDR_W-1:0] UNLOCK_OFS_2 = 26'h00002AA;

	// Status bit positions on the data lines
	localparam int POLLING_BIT = 7;
	localparam int TOGGLE_BIT_ONE = 6;
	localparam int TIMING_LIMIT_BIT = 5;
	localparam int ERASE_WINDOW_BIT = 3;
	localparam int TOGGLE_BIT_TWO = 2;
	localparam int BUFFER_ABORT_BIT = 1;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_WRITE = 3'h1,
		OP_SW_RESET = 3'h2,
		OP_BYPASS_EXIT = 3'h3,
		OP_ABORT_RESET = 3'h4,
		OP_HW_RESET = 3'h5,
		OP_POLL = 3'h6
	} op_e;

	typedef struct packed {
		op_e op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} req_s;

	typedef struct packed {
		logic chip_select_n;
		logic write_strobe_n;
		logic output_strobe_n;
		logic hw_reset_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic dq_oe;
	} pins_s;

	typedef struct packed {
		logic op_ok;
		logic still_busy;
		logic timing_fail;
		logic buffer_aborted;
		logic erase_window;
	} result_s;

endpackage

// file: flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model
	import flash_host_pkg::*;
(
	// Host pins and injected fault
	input wire pins_s pins_in,
	input wire logic [1:0] fault_in,
	// Device outputs
	output logic [DATA_W-1:0] dq_out,
	output logic rb_low_out
);
	logic [DATA_W-1:0] mem [16];
	logic [DATA_W-1:0] h1, h2, last;
	logic [3:0] a;
	logic arm, tog, tl, ab, er, sus;
	int busy;
	wire wr_n = pins_in.write_strobe_n | pins_in.chip_select_n;
	wire [DATA_W-1:0] d = pins_in.dq;
	assign rb_low_out = busy != 0 && !sus; // Open drain, only pulls low
	// Released lines show the inverse, never a stale value
	assign dq_out = (pins_in.output_strobe_n || !pins_in.hw_reset_n) ? ~last : last;
	initial begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
		{arm, tog, tl, ab, er, sus, busy, h1, h2, last, a} = '0;
	end
	always @(negedge pins_in.hw_reset_n) {arm, tl, ab, er, sus, busy} = '0;
	always @(negedge wr_n) a = pins_in.addr[3:0];
	always @(posedge wr_n) if (pins_in.hw_reset_n) begin
		if (tl && d == CMD_SW_RESET) {tl, busy} = '0;
		else if (ab && h2 == CMD_UNLOCK_1 && h1 == CMD_UNLOCK_2 && d == CMD_SW_RESET) {ab, busy} = '0;
		else if (er && busy != 0 && d == 16'h00B0) sus = 1'b1; // Only suspend passes a running erase
		else if (sus && d == 16'h0030) sus = 1'b0; // A software reset leaves the suspend standing
		else if (busy == 0 && !ab && !tl) begin // Lone reset ignored here
			if (arm) begin
				mem[a] &= d;
				busy = (fault_in == 2'h0) ? 2 : -1;
				tl = fault_in == 2'h1;
				ab = fault_in == 2'h2;
				er = 1'b0;
			end else if (h2 == CMD_UNLOCK_1 && h1 == CMD_UNLOCK_2 && d == 16'h0030) begin
				// One sector spans the whole model array
				foreach (mem[i]) mem[i] = 16'hFFFF;
				busy = 6;
				er = 1'b1;
			end
			arm = h1 == CMD_UNLOCK_2 && d == 16'h00A0; // Reset clears the arm
		end
		h2 = h1;
		h1 = d;
	end
	always @(negedge pins_in.output_strobe_n) begin
		last = mem[pins_in.addr[3:0]];
		if (busy != 0 && !sus) begin
			tog = !tog;
			last[POLLING_BIT] = er ? 1'b0 : !last[POLLING_BIT];
			last[TOGGLE_BIT_ONE] = tog;
			last[TIMING_LIMIT_BIT] = tl;
			// Window stays open for the first two status reads
			if (er) last[ERASE_WINDOW_BIT] = (busy <= 4);
			last[TOGGLE_BIT_TWO] = er ? tog : 1'b0;
			last[BUFFER_ABORT_BIT] = ab;
			if (busy > 0) busy--;
		end
	end
endmodule // flash_dev_model

// file: flash_host_ctrl_checker.sv
`timescale 1ns/1ps
module flash_host_ctrl_checker
	import flash_host_pkg::*;
(
	// Watched ports
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic req_valid_in,
	input wire req_s req_in,
	input wire logic req_ready_out,
	input wire pins_s pins_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	wire take = req_valid_in && req_ready_out;
	wire we = !pins_out.write_strobe_n;
	wire rd = !pins_out.output_strobe_n;
	sequence s_we_pulse; we ##1 we ##1 !we; endsequence
	sequence s_exit; (we && pins_out.dq == CMD_BYPASS_EXIT_1) ##[1:8] (we && pins_out.dq == CMD_BYPASS_EXIT_2); endsequence
	property p_we_pulse; $fell(pins_out.write_strobe_n) |-> s_we_pulse; endproperty
	property p_write_qual; we |-> !pins_out.chip_select_n && !rd && pins_out.dq_oe; endproperty
	property p_data_hold; we |=> pins_out.dq_oe && $stable(pins_out.dq) && $stable(pins_out.addr); endproperty
	property p_read_release; rd |-> !pins_out.dq_oe && !pins_out.chip_select_n; endproperty
	property p_sw_reset; take && req_in.op == OP_SW_RESET |-> ##[1:4] (we && pins_out.dq == CMD_SW_RESET); endproperty
	property p_exit_seq; take && req_in.op == OP_BYPASS_EXIT |-> ##[1:4] s_exit; endproperty
	property p_hw_pulse; $fell(pins_out.hw_reset_n) |=> !pins_out.hw_reset_n [*8]; endproperty
	property p_hw_quiet; !pins_out.hw_reset_n |-> pins_out.chip_select_n && !we && !rd; endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("write strobe width");
	a_write_qual: assert property (p_write_qual) else $error("write qualifiers");
	a_data_hold: assert property (p_data_hold) else $error("write data moved");
	a_read_release: assert property (p_read_release) else $error("read bus clash");
	a_sw_reset: assert property (p_sw_reset) else $error("reset word missing");
	a_exit_seq: assert property (p_exit_seq) else $error("bypass exit order");
	a_hw_pulse: assert property (p_hw_pulse) else $error("reset pulse short");
	a_hw_quiet: assert property (p_hw_quiet) else $error("access during reset");
endmodule // flash_host_ctrl_checker
bind flash_host_ctrl flash_host_ctrl_checker i_flash_host_ctrl_checker (.clk_sys_in, .rst_in, .req_valid_in,
	.req_in, .req_ready_out, .pins_out);

// file: test_flash_host_ctrl.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; $display("wrong value %s exp %h got %h", n, e, s); end end
module test_flash_host_ctrl;
	import flash_host_pkg::*;
	logic clk_sys_in = 0, rst_in = 1, req_valid_in = 0, req_ready_out, done_out, ready_out, rb_low;
	req_s req_in = '0;
	logic [DATA_W-1:0] rd_data_out, dev_dq, mem_ref [16];
	result_s result_out;
	pins_s pins_out;
	logic [1:0] fault = 2'h0;
	logic [DATA_W-1:0] wq [$];
	int err_count = 0, n_compared = 0, cyc = 0, seed = 32'h724B;
	wire [DATA_W-1:0] dq_in = pins_out.dq_oe ? pins_out.dq : dev_dq;
	wire ready_busy_n_in = !rb_low;
	wire wr_n = pins_out.write_strobe_n | pins_out.chip_select_n;
	always #20 clk_sys_in = !clk_sys_in;
	flash_host_ctrl i_flash_host_ctrl (.clk_sys_in, .rst_in, .req_valid_in, .req_in, .req_ready_out, .done_out,
		.rd_data_out, .result_out, .ready_out, .pins_out, .dq_in, .ready_busy_n_in);
	flash_dev_model i_flash_dev_model (.pins_in(pins_out), .fault_in(fault), .dq_out(dev_dq), .rb_low_out(rb_low));
	always @(posedge wr_n) wq.push_back(pins_out.dq);
	task automatic conclude();
		if (err_count == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc > 10000) begin
			err_count++;
			conclude();
		end
	end
	task automatic op(op_e o, logic [ADDR_W-1:0] ad, logic [DATA_W-1:0] d);
		int n;
		n = 0;
		req_in <= '{o, ad, d};
		req_valid_in <= 1'b1;
		@(posedge clk_sys_in);
		req_valid_in <= 1'b0;
		do begin
			@(negedge clk_sys_in);
			n++;
		end while (done_out !== 1'b1 && n < 100);
		// A missing answer counts as a mismatch
		if (done_out !== 1'b1) err_count++;
		@(posedge clk_sys_in);
	endtask
	task automatic prog(logic [3:0] a, logic [DATA_W-1:0] d, logic [1:0] f, logic go);
		fault <= f;
		op(OP_WRITE, UNLOCK_OFS_1, CMD_UNLOCK_1);
		op(OP_WRITE, UNLOCK_OFS_2, CMD_UNLOCK_2);
		if (go) op(OP_WRITE, UNLOCK_OFS_1, 16'h00A0);
		else op(OP_SW_RESET, UNLOCK_OFS_1, CMD_SW_RESET);
		op(OP_WRITE, ADDR_W'(a), d);
		if (go) mem_ref[a] &= d;
	endtask
	initial begin
		logic [3:0] a;
		logic [DATA_W-1:0] d;
		foreach (mem_ref[i]) mem_ref[i] = 16'hFFFF;
		repeat (20) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			a = 4'($random(seed));
			d = 16'($random(seed));
			prog(a, d, 2'(i % 4 == 3 ? 1 : i % 4), 1'b1);
			case (i % 4)
				0: begin
					op(OP_SW_RESET, ADDR_W'(a), CMD_SW_RESET);
					`CHK("reset word", CMD_SW_RESET, wq[$])
					`CHK("ready pin", 1'b0, ready_out)
					op(OP_POLL, ADDR_W'(a), '0);
					`CHK("still busy", 1'b1, result_out.still_busy)
					op(OP_POLL, ADDR_W'(a), '0);
					`CHK("done ok", 1'b1, result_out.op_ok)
				end
				1: begin
					op(OP_POLL, ADDR_W'(a), '0);
					`CHK("timing", 1'b1, result_out.timing_fail)
					`CHK("reset after limit", CMD_SW_RESET, wq[$])
				end
				2: begin
					op(OP_POLL, ADDR_W'(a), '0);
					`CHK("abort", 1'b1, result_out.buffer_aborted)
					`CHK("abort reset start", CMD_UNLOCK_1, wq[$-2])
					`CHK("abort reset end", CMD_SW_RESET, wq[$])
				end
				default: begin
					op(OP_HW_RESET, '0, '0);
					prog(a, 16'($random(seed)), 2'h0, 1'b0);
				end
			endcase
			op(OP_READ, ADDR_W'(a), '0);
			`CHK("array word", mem_ref[a], rd_data_out)
			`CHK("ready idle", 1'b1, ready_out)
		end
		op(OP_WRITE, UNLOCK_OFS_1, CMD_UNLOCK_1);
		op(OP_WRITE, UNLOCK_OFS_2, CMD_UNLOCK_2);
		op(OP_WRITE, UNLOCK_OFS_1, 16'h0080);
		op(OP_WRITE, UNLOCK_OFS_1, CMD_UNLOCK_1);
		op(OP_WRITE, UNLOCK_OFS_2, CMD_UNLOCK_2);
		op(OP_WRITE, ADDR_W'(a), 16'h0030);
		foreach (mem_ref[i]) mem_ref[i] = 16'hFFFF;
		op(OP_POLL, ADDR_W'(a), '0);
		`CHK("window open", 1'b0, result_out.erase_window)
		op(OP_POLL, ADDR_W'(a), '0);
		`CHK("window shut", 1'b1, result_out.erase_window)
		op(OP_WRITE, '0, 16'h00B0);
		op(OP_SW_RESET, '0, CMD_SW_RESET);
		op(OP_POLL, ADDR_W'(a), '0);
		`CHK("suspend read", 1'b1, result_out.op_ok)
		`CHK("ready in suspend", 1'b1, ready_out)
		op(OP_WRITE, '0, 16'h0030);
		op(OP_POLL, ADDR_W'(a), '0);
		`CHK("erase resumed", 1'b1, result_out.still_busy)
		op(OP_POLL, ADDR_W'(a), '0);
		`CHK("erase done", 1'b1, result_out.op_ok)
		op(OP_READ, ADDR_W'(a ^ 4'h5), '0);
		`CHK("sector erased", mem_ref[a ^ 4'h5], rd_data_out)
		op(OP_BYPASS_EXIT, '0, '0);
		`CHK("exit first", CMD_BYPASS_EXIT_1, wq[$-1])
		`CHK("exit second", CMD_BYPASS_EXIT_2, wq[$])
		conclude();
	end
endmodule // test_flash_host_ctrl
